// *** rtl/dual_edge_ctrl_pkg.sv ***
// Constants for the dual-edge sampling and output control block.
// Assumes a 16-bit configuration word and 10-bit converter words.
package dual_edge_ctrl_pkg;

  // Widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int WORD_W = 10;
  localparam int ENTRY_W = 4 * WORD_W;
  localparam int TRIM_W = 6;
  localparam int DELAY_CODE_W = 7;
  localparam int LCF_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_MAIN_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CM_ADJ = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CLK_DLY = 4'hd;

  // main_configuration fields
  localparam int BIT_CLK_PHASE = 14;
  localparam int BIT_SWING = 13;
  localparam int BIT_PD_I = 11;
  localparam int BIT_PD_Q = 10;
  localparam int BIT_DES = 7;
  localparam int BIT_Q_SRC = 6;
  localparam int BIT_BOTH_IN = 5;
  // common_mode_adjust field
  localparam int BIT_CM_LOWER = 0;
  // clock_delay_filter_control fields
  localparam int BIT_PHASE_DLY_EN = 8;
  localparam int LCF_LSB = 0;
  localparam int DELAY_LSB = 9;

  // Reset values
  localparam logic [DATA_W-1:0] MAIN_CFG_RST = 16'h2000;
  localparam logic [DATA_W-1:0] CM_ADJ_RST = 16'h0000;
  localparam logic [DATA_W-1:0] CLK_DLY_RST = 16'h0000;

  // Analog figures reported to the front end
  localparam logic [9:0] MAX_DELAY_PS = 10'd825;
  localparam logic [9:0] DELAY_STEP_PS = 10'd7;
  localparam logic [7:0] CM_DROP_MV = 8'd200;
  localparam logic [TRIM_W-1:0] TRIM_MID = 6'h20;

  // Filter centre frequency in MHz per count of ones
  localparam logic [11:0] FC_MHZ [0:8] = '{12'd1500, 12'd1400, 12'd1300, 12'd1200,
                                          12'd1100, 12'd1000, 12'd920, 12'd850, 12'd800};

  // Dual-edge input source
  typedef enum logic [2:0] {
    SRC_I = 3'b001,
    SRC_Q = 3'b010,
    SRC_IQ = 3'b100
  } src_e;

  // Link side cell sequencer
  typedef enum logic [2:0] {
    LK_IDLE = 3'b001,
    LK_FIRST = 3'b010,
    LK_SECOND = 3'b100
  } link_state_e;

endpackage : dual_edge_ctrl_pkg

// *** rtl/dual_edge_sampling_output_ctrl.sv ***
// Mode, clock-delay and DDR output control of a dual-channel converter.
// Assumes converter words arrive on mclk_in and the capture side runs on link_clk_in.
`timescale 1ns/100ps

module dual_edge_sampling_output_ctrl
  import dual_edge_ctrl_pkg::*;
(
  input wire logic mclk_in,                         // Core clock, 250 MHz
  input wire logic arst_n_in,                       // Async reset, active low
  input wire logic link_clk_in,                     // Output link clock
  // Configuration pins
  input wire logic extended_control_in,             // Pin: register control active
  input wire logic des_pin_in,                      // Pin: dual-edge mode
  input wire logic clk_phase_pin_in,                // Pin: 90 degree output phase
  input wire logic demux_pin_in,                    // Pin: 1:2 / 1:4 demux
  input wire logic pd_i_pin_in,                     // Pin: power down I
  input wire logic pd_q_pin_in,                     // Pin: power down Q
  // Register port
  input wire logic reg_wr_en_in,                    // Register write strobe
  input wire logic [ADDR_W-1:0] reg_addr_in,        // Register address
  input wire logic [DATA_W-1:0] reg_wdata_in,       // Register write data
  output logic [DATA_W-1:0] reg_rdata_out,          // Register read data
  // Converter side
  input wire logic adc_valid_in,                    // I/Q sample pair present
  input wire logic [WORD_W-1:0] adc_i_word_in,      // Later sample word
  input wire logic [WORD_W-1:0] adc_q_word_in,      // Earlier sample word
  output logic adc_ready_out,                       // Buffer can take a pair
  input wire logic phase_err_up_in,                 // Phase detector: Q lags
  input wire logic phase_err_dn_in,                 // Phase detector: Q leads
  // Analog control outputs
  output logic des_mode_out,                        // Dual-edge active
  output logic q_on_falling_out,                    // Q converter on falling edge
  output logic q_source_sel_out,                    // Both converters take Q input
  output logic both_inputs_sel_out,                 // Each converter own input
  output logic des_invalid_out,                     // Dual-edge with a channel down
  output logic pd_i_out,                            // I channel powered down
  output logic pd_q_out,                            // Q channel powered down
  output logic [TRIM_W-1:0] phase_trim_out,         // Background I/Q phase trim
  output logic phase_delay_enable_out,              // Clock delay and filter on
  output logic [9:0] sample_delay_ps_out,           // Sampling clock delay
  output logic [3:0] filter_centre_code_out,        // Filter step, ones count
  output logic [11:0] filter_centre_mhz_out,        // Filter centre frequency
  output logic cm_lower_out,                        // Common mode lowered
  output logic [7:0] cm_drop_mv_out,                // Size of the lowering
  output logic output_swing_sel_out,                // 1 = higher output swing
  // Link side, on link_clk_in
  input wire logic link_ready_in,                   // Receiver accepts next cell
  output logic link_valid_out,                      // Cell carries data
  output logic output_clock_out,                    // DDR data clock
  output logic [WORD_W-1:0] q_delayed_bus_out,      // Earliest word
  output logic [WORD_W-1:0] i_delayed_bus_out,      // Second word
  output logic [WORD_W-1:0] q_bus_out,              // Third word
  output logic [WORD_W-1:0] i_bus_out               // Latest word
);

  // Reset synchronisers, one per domain
  logic rst_m1_ff, rst_m_ff, rst_l1_ff, rst_l_ff;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_m1_ff <= 1'b0;
      rst_m_ff <= 1'b0;
    end else begin
      rst_m1_ff <= 1'b1;
      rst_m_ff <= rst_m1_ff;
    end
  end

  always_ff @(posedge link_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_l1_ff <= 1'b0;
      rst_l_ff <= 1'b0;
    end else begin
      rst_l1_ff <= 1'b1;
      rst_l_ff <= rst_l1_ff;
    end
  end

  // Pin synchronisers; stage one is read only by stage two
  logic [5:0] pin_raw, pin_s1_ff, pin_ff;
  assign pin_raw = {pd_q_pin_in, pd_i_pin_in, demux_pin_in, clk_phase_pin_in, des_pin_in, extended_control_in};

  always_ff @(posedge mclk_in or negedge rst_m_ff) begin
    if (!rst_m_ff) begin
      pin_s1_ff <= 6'h00;
      pin_ff <= 6'h00;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_ff <= pin_s1_ff;
    end
  end

  logic extended_control, des_pin, phase_pin, demux_mode, pd_i_pin, pd_q_pin;
  assign {pd_q_pin, pd_i_pin, demux_mode, phase_pin, des_pin, extended_control} = pin_ff;

  // Configuration registers
  logic [DATA_W-1:0] main_cfg_ff, cm_adj_ff, clk_dly_ff;

  // Writes only land under extended control; pin mode leaves registers alone
  always_ff @(posedge mclk_in or negedge rst_m_ff) begin
    if (!rst_m_ff) begin
      main_cfg_ff <= MAIN_CFG_RST;
      cm_adj_ff <= CM_ADJ_RST;
      clk_dly_ff <= CLK_DLY_RST;
    end else if (reg_wr_en_in && extended_control) begin
      case (reg_addr_in)
        OFS_MAIN_CFG: main_cfg_ff <= reg_wdata_in;
        OFS_CM_ADJ: cm_adj_ff <= reg_wdata_in;
        OFS_CLK_DLY: clk_dly_ff <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Read mux; unmapped offsets read zero
  logic [DATA_W-1:0] nxt_rdata;
  always_comb begin
    case (reg_addr_in)
      OFS_MAIN_CFG: nxt_rdata = main_cfg_ff;
      OFS_CM_ADJ: nxt_rdata = cm_adj_ff;
      OFS_CLK_DLY: nxt_rdata = clk_dly_ff;
      default: nxt_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_m_ff) begin
    if (!rst_m_ff) begin
      reg_rdata_out <= 16'h0000;
    end else begin
      reg_rdata_out <= nxt_rdata;
    end
  end

  // Mode and source selection
  logic des_mode;
  src_e src_sel;
  assign des_mode = extended_control ? main_cfg_ff[BIT_DES] : des_pin;

  always_comb begin
    if (!extended_control) begin
      src_sel = SRC_I;
    end else if (main_cfg_ff[BIT_BOTH_IN]) begin
      src_sel = SRC_IQ;
    end else if (main_cfg_ff[BIT_Q_SRC]) begin
      src_sel = SRC_Q;
    end else begin
      src_sel = SRC_I;
    end
  end

  // Front-end steering, registered to keep glitches off the analog controls
  always_ff @(posedge mclk_in or negedge rst_m_ff) begin
    if (!rst_m_ff) begin
      des_mode_out <= 1'b0;
      q_on_falling_out <= 1'b0;
      q_source_sel_out <= 1'b0;
      both_inputs_sel_out <= 1'b0;
      pd_i_out <= 1'b0;
      pd_q_out <= 1'b0;
      des_invalid_out <= 1'b0;
    end else begin
      des_mode_out <= des_mode;
      q_on_falling_out <= des_mode;
      q_source_sel_out <= des_mode && (src_sel == SRC_Q);
      both_inputs_sel_out <= des_mode && (src_sel == SRC_IQ);
      pd_i_out <= pd_i_pin || (extended_control && main_cfg_ff[BIT_PD_I]);
      pd_q_out <= pd_q_pin || (extended_control && main_cfg_ff[BIT_PD_Q]);
      // Flag only; the controller is trusted to keep both channels up
      des_invalid_out <= des_mode && (pd_i_pin || pd_q_pin ||
                         (extended_control && (main_cfg_ff[BIT_PD_I] || main_cfg_ff[BIT_PD_Q])));
    end
  end

  // Background phase trim; held at its last value outside dual-edge mode
  always_ff @(posedge mclk_in or negedge rst_m_ff) begin
    if (!rst_m_ff) begin
      phase_trim_out <= TRIM_MID;
    end else if (des_mode) begin
      if (phase_err_up_in && !phase_err_dn_in && phase_trim_out != 6'h3f) begin
        phase_trim_out <= phase_trim_out + 6'h01;
      end else if (phase_err_dn_in && !phase_err_up_in && phase_trim_out != 6'h00) begin
        phase_trim_out <= phase_trim_out - 6'h01;
      end
    end
  end

  // Thermometer decode: count contiguous ones from the LSB
  logic [LCF_W-1:0] lcf_field, therm_run;
  logic [3:0] ones_cnt;
  assign lcf_field = clk_dly_ff[LCF_LSB +: LCF_W];

  genvar gb;
  generate
    for (gb = 0; gb < LCF_W; gb++) begin : g_therm
      assign therm_run[gb] = &lcf_field[gb:0];
    end
  endgenerate

  always_comb begin
    ones_cnt = 4'h0;
    for (int k = 0; k < LCF_W; k++) begin
      ones_cnt = ones_cnt + {3'b000, therm_run[k]};
    end
  end

  // Clock delay and filter controls; both gated by the one enable bit
  logic dly_en;
  logic [9:0] dly_raw;
  assign dly_en = extended_control && clk_dly_ff[BIT_PHASE_DLY_EN];
  assign dly_raw = 10'(clk_dly_ff[DELAY_LSB +: DELAY_CODE_W] * DELAY_STEP_PS);

  always_ff @(posedge mclk_in or negedge rst_m_ff) begin
    if (!rst_m_ff) begin
      phase_delay_enable_out <= 1'b0;
      sample_delay_ps_out <= 10'h000;
      filter_centre_code_out <= 4'h0;
      filter_centre_mhz_out <= FC_MHZ[0];
    end else begin
      phase_delay_enable_out <= dly_en;
      // Saturate so no code asks for more than the delay line can give
      sample_delay_ps_out <= !dly_en ? 10'h000 : (dly_raw > MAX_DELAY_PS ? MAX_DELAY_PS : dly_raw);
      filter_centre_code_out <= dly_en ? ones_cnt : 4'h0;
      filter_centre_mhz_out <= dly_en ? FC_MHZ[ones_cnt] : FC_MHZ[0];
    end
  end

  // Common mode and output swing
  always_ff @(posedge mclk_in or negedge rst_m_ff) begin
    if (!rst_m_ff) begin
      cm_lower_out <= 1'b0;
      cm_drop_mv_out <= 8'h00;
      output_swing_sel_out <= 1'b1;
    end else begin
      cm_lower_out <= extended_control && cm_adj_ff[BIT_CM_LOWER];
      cm_drop_mv_out <= (extended_control && cm_adj_ff[BIT_CM_LOWER]) ? CM_DROP_MV : 8'h00;
      // Pin control only offers the higher swing
      output_swing_sel_out <= !extended_control || main_cfg_ff[BIT_SWING];
    end
  end

  // Word packing: in demux the first pair becomes the delayed words
  logic pair_ff;
  logic [2*WORD_W-1:0] held_pair_ff;
  logic wr_take, wr_push;
  logic [ENTRY_W-1:0] wr_entry;
  logic [1:0] wr_bin_ff, wr_gray, rd_gray_s1_ff, rd_gray_s_ff;
  logic fifo_full;

  assign wr_gray = wr_bin_ff ^ (wr_bin_ff >> 1);
  assign fifo_full = (wr_gray == ~rd_gray_s_ff);
  // First demux pair only needs the holding register, never the buffer
  assign adc_ready_out = !fifo_full || (demux_mode && !pair_ff);
  assign wr_take = adc_valid_in && adc_ready_out;
  assign wr_push = wr_take && (!demux_mode || pair_ff);
  assign wr_entry = demux_mode ? {held_pair_ff, adc_q_word_in, adc_i_word_in}
                               : {{2*WORD_W{1'b0}}, adc_q_word_in, adc_i_word_in};

  always_ff @(posedge mclk_in or negedge rst_m_ff) begin
    if (!rst_m_ff) begin
      pair_ff <= 1'b0;
      held_pair_ff <= '0;
    end else if (wr_take) begin
      pair_ff <= demux_mode && !pair_ff;
      if (demux_mode && !pair_ff) begin
        held_pair_ff <= {adc_q_word_in, adc_i_word_in};
      end
    end
  end

  // Two-entry crossing buffer, gray pointers each way
  logic [ENTRY_W-1:0] fifo_mem [0:1];

  always_ff @(posedge mclk_in) begin
    if (wr_push) begin
      fifo_mem[wr_bin_ff[0]] <= wr_entry;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_m_ff) begin
    if (!rst_m_ff) begin
      wr_bin_ff <= 2'b00;
    end else if (wr_push) begin
      wr_bin_ff <= wr_bin_ff + 2'b01;
    end
  end

  logic [1:0] rd_bin_ff, rd_gray, wr_gray_s1_ff, wr_gray_s_ff;
  assign rd_gray = rd_bin_ff ^ (rd_bin_ff >> 1);

  always_ff @(posedge mclk_in or negedge rst_m_ff) begin
    if (!rst_m_ff) begin
      rd_gray_s1_ff <= 2'b00;
      rd_gray_s_ff <= 2'b00;
    end else begin
      rd_gray_s1_ff <= rd_gray;
      rd_gray_s_ff <= rd_gray_s1_ff;
    end
  end

  // Link domain: synchronised write pointer and phase setting
  logic phase_sel, ph_s1_ff, ph_s_ff;
  assign phase_sel = extended_control ? main_cfg_ff[BIT_CLK_PHASE] : phase_pin;

  logic phase_src_ff;
  always_ff @(posedge mclk_in or negedge rst_m_ff) begin
    if (!rst_m_ff) begin
      phase_src_ff <= 1'b0;
    end else begin
      phase_src_ff <= phase_sel;
    end
  end

  always_ff @(posedge link_clk_in or negedge rst_l_ff) begin
    if (!rst_l_ff) begin
      wr_gray_s1_ff <= 2'b00;
      wr_gray_s_ff <= 2'b00;
      ph_s1_ff <= 1'b0;
      ph_s_ff <= 1'b0;
    end else begin
      wr_gray_s1_ff <= wr_gray;
      wr_gray_s_ff <= wr_gray_s1_ff;
      ph_s1_ff <= phase_src_ff;
      ph_s_ff <= ph_s1_ff;
    end
  end

  // Cell sequencer: each DDR cell spans two link clocks
  link_state_e lk_state_ff, nxt_lk_state;
  logic fifo_empty, rd_pop;
  assign fifo_empty = (rd_gray == wr_gray_s_ff);
  assign rd_pop = !fifo_empty && link_ready_in && (lk_state_ff != LK_FIRST);

  always_comb begin
    case (lk_state_ff)
      LK_IDLE: nxt_lk_state = rd_pop ? LK_FIRST : LK_IDLE;
      LK_FIRST: nxt_lk_state = LK_SECOND;
      LK_SECOND: nxt_lk_state = rd_pop ? LK_FIRST : LK_IDLE;
      default: nxt_lk_state = LK_IDLE;
    endcase
  end

  always_ff @(posedge link_clk_in or negedge rst_l_ff) begin
    if (!rst_l_ff) begin
      lk_state_ff <= LK_IDLE;
      rd_bin_ff <= 2'b00;
    end else begin
      lk_state_ff <= nxt_lk_state;
      if (rd_pop) begin
        rd_bin_ff <= rd_bin_ff + 2'b01;
      end
    end
  end

  // Output words change only at a cell boundary
  always_ff @(posedge link_clk_in or negedge rst_l_ff) begin
    if (!rst_l_ff) begin
      link_valid_out <= 1'b0;
      {q_delayed_bus_out, i_delayed_bus_out, q_bus_out, i_bus_out} <= '0;
    end else if (rd_pop) begin
      link_valid_out <= 1'b1;
      {q_delayed_bus_out, i_delayed_bus_out, q_bus_out, i_bus_out} <= fifo_mem[rd_bin_ff[0]];
    end else if (lk_state_ff == LK_SECOND) begin
      link_valid_out <= 1'b0;
    end
  end

  // Data clock: one toggle per cell, so it runs at half the data rate
  logic clk_toggle;
  assign clk_toggle = ph_s_ff ? (lk_state_ff == LK_FIRST) : rd_pop;

  always_ff @(posedge link_clk_in or negedge rst_l_ff) begin
    if (!rst_l_ff) begin
      output_clock_out <= 1'b0;
    end else if (clk_toggle) begin
      output_clock_out <= !output_clock_out;
    end
  end

endmodule : dual_edge_sampling_output_ctrl

// *** sim/capture_model.sv ***
// Capture logic at the far end of the DDR link.
// Assumes two-cycle cells; samples on the falling link edge.
`timescale 1ns/100ps
module capture_model (
  input wire logic link_clk_in,  // Link clock
  input wire logic arst_n_in,    // Async reset, active low
  input wire logic stall_in,     // Hold off the sender
  input wire logic demux_in,     // Four words per cell
  input wire logic valid_in,     // Cell carries data
  input wire logic output_clock_in,      // DDR data clock
  input wire logic [9:0] qd_in,  // Earliest word
  input wire logic [9:0] id_in,  // Second word
  input wire logic [9:0] q_in,   // Third word
  input wire logic [9:0] i_in,   // Latest word
  output logic ready_out,        // Accepts next cell
  output logic aligned_out       // Cell began on clock edge
);
  logic [9:0] stream [$]; // Samples, earliest first
  logic [39:0] last_cell;
  logic last_clk;
  logic [1:0] beat;

  // Slow receiver: refuses every fourth cycle and while stalled
  always @(posedge link_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ready_out <= 1'b0;
      beat <= 2'h0;
    end else begin
      beat <= beat + 2'h1;
      ready_out <= !stall_in && beat != 2'h3;
    end
  end

  // Mid-cell sampling avoids racing the sender's edge
  always @(negedge link_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aligned_out <= 1'b0;
      last_cell <= 40'h0;
      last_clk <= 1'b0;
    end else begin
      if (valid_in && {qd_in, id_in, q_in, i_in} !== last_cell) begin
        if (demux_in) begin
          stream.push_back(qd_in);
          stream.push_back(id_in);
        end
        stream.push_back(q_in);
        stream.push_back(i_in);
        aligned_out <= output_clock_in !== last_clk;
      end
      last_cell <= {qd_in, id_in, q_in, i_in};
      last_clk <= output_clock_in;
    end
  end
endmodule : capture_model

// *** sim/dual_edge_ctrl_chk.sv ***
// Concurrent checks on the control block's top-level ports.
// Assumes the package compiled first; bind at the end.
`timescale 1ns/100ps
module dual_edge_ctrl_chk
  import dual_edge_ctrl_pkg::*;
(
  input wire logic mclk_in,                     // Core clock
  input wire logic arst_n_in,                   // Async reset, active low
  input wire logic link_clk_in,                 // Link clock
  input wire logic extended_control_in,         // Register control pin
  input wire logic des_mode_out,                // Dual-edge active
  input wire logic q_on_falling_out,            // Q on falling edge
  input wire logic q_source_sel_out,            // Q input source
  input wire logic both_inputs_sel_out,         // Both inputs driven
  input wire logic [TRIM_W-1:0] phase_trim_out, // Background trim
  input wire logic phase_delay_enable_out,      // Delay and filter on
  input wire logic [9:0] sample_delay_ps_out,   // Clock delay
  input wire logic [3:0] filter_centre_code_out, // Filter ones count
  input wire logic [11:0] filter_centre_mhz_out, // Filter centre
  input wire logic cm_lower_out,                // Common mode lowered
  input wire logic [7:0] cm_drop_mv_out,        // Lowering size
  input wire logic link_valid_out,              // Cell carries data
  input wire logic output_clock_out,            // DDR data clock
  input wire logic [WORD_W-1:0] q_bus_out,      // Third word
  input wire logic [WORD_W-1:0] i_bus_out       // Latest word
);
  logic [3:0] pin_cnt_ff; // Settled pin-control cycles

  // Pin-control cycles; the synchroniser hides the first few
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_cnt_ff <= 4'h0;
    end else if (extended_control_in) begin
      pin_cnt_ff <= 4'h0;
    end else if (pin_cnt_ff != 4'hf) begin
      pin_cnt_ff <= pin_cnt_ff + 4'h1;
    end
  end

  filter_map_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    $stable(filter_centre_code_out) && filter_centre_code_out <= 4'h8
    |-> filter_centre_mhz_out == FC_MHZ[filter_centre_code_out]) else $error("filter centre mismatch");
  filter_gate_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    !phase_delay_enable_out && $past(phase_delay_enable_out) == 1'b0
    |-> filter_centre_code_out == 4'h0 && sample_delay_ps_out == 10'h000) else $error("filter or delay active");
  delay_step_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    sample_delay_ps_out <= MAX_DELAY_PS && ((sample_delay_ps_out % DELAY_STEP_PS) == 10'h000
    || sample_delay_ps_out == MAX_DELAY_PS)) else $error("delay out of range");
  cm_drop_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    $stable(cm_lower_out) |-> cm_drop_mv_out == (cm_lower_out ? CM_DROP_MV : 8'h00)) else $error("bad cm drop");
  pin_source_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    pin_cnt_ff == 4'hf |-> !q_source_sel_out && !both_inputs_sel_out) else $error("pin control source not I");
  src_prio_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    both_inputs_sel_out && $stable(both_inputs_sel_out) |-> !q_source_sel_out) else $error("two sources at once");
  edge_split_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    $stable(des_mode_out) |-> q_on_falling_out == des_mode_out) else $error("falling edge use wrong");
  trim_idle_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    $changed(phase_trim_out) |-> des_mode_out || $past(des_mode_out)) else $error("trim moved outside dual-edge");
  cell_hold_a: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
    $rose(link_valid_out) |=> $stable(q_bus_out) && $stable(i_bus_out)) else $error("cell words left early");
  cell_clock_a: assert property (@(posedge link_clk_in) disable iff (!arst_n_in)
    $rose(link_valid_out) |-> ##[0:1] $changed(output_clock_out)) else $error("no data clock edge in cell");
endmodule : dual_edge_ctrl_chk

bind dual_edge_sampling_output_ctrl dual_edge_ctrl_chk chk_i (.*);

// *** sim/test_dual_edge_sampling_output_ctrl.sv ***
// Self-checking bench for the dual-edge control block.
// Assumes package, design, checker and model compiled first.
`timescale 1ns/100ps
module test_dual_edge_sampling_output_ctrl
  import dual_edge_ctrl_pkg::*;
;
  logic mclk_in, arst_n_in, link_clk_in, extended_control_in, des_pin_in, clk_phase_pin_in;
  logic demux_pin_in, pd_i_pin_in, pd_q_pin_in, reg_wr_en_in, adc_valid_in, adc_ready_out;
  logic phase_err_up_in, phase_err_dn_in, des_mode_out, q_on_falling_out, q_source_sel_out;
  logic both_inputs_sel_out, des_invalid_out, pd_i_out, pd_q_out, phase_delay_enable_out;
  logic cm_lower_out, output_swing_sel_out, link_ready_in, link_valid_out, output_clock_out, stall_in;
  logic [ADDR_W-1:0] reg_addr_in;
  logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out;
  logic [WORD_W-1:0] adc_i_word_in, adc_q_word_in, q_delayed_bus_out, i_delayed_bus_out, q_bus_out, i_bus_out;
  logic [TRIM_W-1:0] phase_trim_out;
  logic [9:0] sample_delay_ps_out;
  logic [3:0] filter_centre_code_out;
  logic [11:0] filter_centre_mhz_out;
  logic [7:0] cm_drop_mv_out;
  logic [8:0] therm;
  int bad_count, n_compared, refused, n;
  logic [15:0] cfg_tab [4] = '{16'h2000, 16'h00c0, 16'h20e0, 16'h2080};
  logic [15:0] exp_tab [4] = '{16'h0001, 16'h000c, 16'h000b, 16'h0009};

  dual_edge_sampling_output_ctrl DUT (.*);
  capture_model cap (.link_clk_in, .arst_n_in, .stall_in, .demux_in(demux_pin_in), .valid_in(link_valid_out),
    .output_clock_in(output_clock_out), .qd_in(q_delayed_bus_out), .id_in(i_delayed_bus_out), .q_in(q_bus_out),
    .i_in(i_bus_out), .ready_out(link_ready_in), .aligned_out());

  // Two unrelated clocks: 4 ns core, 48 ns link
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  initial begin
    link_clk_in = 1'b0;
    #7;
    forever #24 link_clk_in = ~link_clk_in;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // One-cycle strobe; outputs settle by the third edge
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge mclk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_en_in = 1'b1;
    @(negedge mclk_in);
    reg_wr_en_in = 1'b0;
    repeat (4) @(negedge mclk_in);
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
    @(negedge mclk_in);
    reg_addr_in = a;
    @(negedge mclk_in);
    chk(reg_rdata_out, exp);
  endtask : reg_rd

  // Pairs back to back; ready is read before the taking edge to avoid a race
  task automatic send(input int cnt, input logic [9:0] base);
    int k, w;
    for (k = 0; k < cnt; k++) begin
      @(negedge mclk_in);
      adc_valid_in = 1'b1;
      adc_q_word_in = base + 10'(2 * k);
      adc_i_word_in = base + 10'(2 * k + 1);
      w = 0;
      while (adc_ready_out !== 1'b1 && w < 2000) begin
        refused++;
        @(negedge mclk_in);
        w++;
      end
      @(posedge mclk_in);
    end
    @(negedge mclk_in);
    adc_valid_in = 1'b0;
  endtask : send

  task automatic burst(input int cnt, input logic [9:0] base, input logic al);
    int j0, w, j;
    // Let synced pins settle before the first pair
    repeat (4) @(negedge mclk_in);
    j0 = cap.stream.size();
    send(cnt, base);
    w = 0;
    while (cap.stream.size() < j0 + 2 * cnt && w < 4000) begin
      @(negedge mclk_in);
      w++;
    end
    for (j = 0; j < 2 * cnt; j++) begin
      chk({6'h0, cap.stream[j0 + j]}, {6'h0, base + 10'(j)});
    end
    chk({15'h0, cap.aligned_out}, {15'h0, al});
  endtask : burst

  // Watchdog well past the ~5 us run
  initial begin
    #200000;
    bad_count++;
    results();
  end

  initial begin
    {extended_control_in, des_pin_in, clk_phase_pin_in, demux_pin_in, pd_i_pin_in, pd_q_pin_in} = 6'h0;
    {reg_wr_en_in, adc_valid_in, phase_err_up_in, phase_err_dn_in, stall_in} = 5'h0;
    {reg_addr_in, reg_wdata_in, adc_i_word_in, adc_q_word_in} = '0;
    arst_n_in = 1'b0;
    repeat (2) @(posedge link_clk_in);
    @(negedge mclk_in);
    arst_n_in = 1'b1;
    repeat (4) @(negedge mclk_in);
    reg_rd(OFS_MAIN_CFG, 16'h2000);
    reg_rd(OFS_CM_ADJ, 16'h0000);
    reg_rd(OFS_CLK_DLY, 16'h0000);
    reg_rd(4'h5, 16'h0000);
    chk({8'h0, phase_trim_out, filter_centre_mhz_out == 12'h5dc, output_swing_sel_out}, 16'h0083);
    // Pin control: I source only, writes refused
    des_pin_in = 1'b1;
    pd_i_pin_in = 1'b1;
    repeat (8) @(negedge mclk_in);
    chk({11'h0, des_mode_out, q_source_sel_out, both_inputs_sel_out, des_invalid_out, pd_i_out}, 16'h0013);
    pd_i_pin_in = 1'b0;
    reg_wr(OFS_MAIN_CFG, 16'h00c0);
    reg_rd(OFS_MAIN_CFG, 16'h2000);
    burst(4, 10'h100, 1'b1);
    clk_phase_pin_in = 1'b1;
    burst(4, 10'h140, 1'b0);
    // Register control: mode, source and swing table
    extended_control_in = 1'b1;
    repeat (6) @(negedge mclk_in);
    for (n = 0; n < 4; n++) begin
      reg_wr(OFS_MAIN_CFG, cfg_tab[n]);
      reg_rd(OFS_MAIN_CFG, cfg_tab[n]);
      chk({12'h0, des_mode_out, q_source_sel_out, both_inputs_sel_out, output_swing_sel_out}, exp_tab[n]);
    end
    phase_err_up_in = 1'b1;
    repeat (40) @(negedge mclk_in);
    phase_err_up_in = 1'b0;
    chk({15'h0, phase_trim_out != TRIM_MID}, 16'h0001);
    // Demux cells with the receiver stalled: buffer fills and refuses
    demux_pin_in = 1'b1;
    stall_in = 1'b1;
    refused = 0;
    fork
      burst(6, 10'h200, 1'b1);
      begin
        repeat (300) @(negedge mclk_in);
        stall_in = 1'b0;
      end
    join
    chk({15'h0, refused > 0}, 16'h0001);
    reg_wr(OFS_MAIN_CFG, 16'h6080);
    burst(4, 10'h280, 1'b0);
    // Thermometer codes, delay code 10
    for (n = 0; n <= 8; n++) begin
      therm = (9'h001 << n) - 9'h001;
      reg_wr(OFS_CLK_DLY, {7'h0a, 1'b1, therm[7:0]});
      chk({12'h0, filter_centre_code_out}, 16'(n));
      chk({4'h0, filter_centre_mhz_out}, {4'h0, FC_MHZ[n]});
      chk({5'h0, phase_delay_enable_out, sample_delay_ps_out}, 16'h0446);
    end
    reg_wr(OFS_CLK_DLY, 16'hfeff);
    reg_rd(OFS_CLK_DLY, 16'hfeff);
    chk({phase_delay_enable_out, filter_centre_code_out, sample_delay_ps_out, 1'b0}, 16'h0000);
    chk({4'h0, filter_centre_mhz_out}, 16'h05dc);
    reg_wr(OFS_CLK_DLY, 16'hff00);
    chk({6'h0, sample_delay_ps_out}, 16'h0339);
    // Common mode lowering on and off
    reg_wr(OFS_CM_ADJ, 16'h0001);
    chk({7'h0, cm_lower_out, cm_drop_mv_out}, 16'h01c8);
    reg_wr(OFS_CM_ADJ, 16'h0000);
    chk({7'h0, cm_lower_out, cm_drop_mv_out}, 16'h0000);
    results();
  end
endmodule : test_dual_edge_sampling_output_ctrl
